// ### common/ssg_pkg.sv
package ssg_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  // Printed offsets are not all multiples of four: they are indices.
  localparam logic [7:0] IDX_CRC_CONTROL  = 8'h03;
  localparam logic [7:0] IDX_TARGET_ADDR  = 8'h08;
  localparam logic [7:0] IDX_TARGET_ALIAS = 8'h09;
  localparam logic [7:0] IDX_CRC_LOW      = 8'h0a;
  localparam logic [7:0] IDX_CRC_HIGH     = 8'h0b;
  localparam logic [7:0] IDX_STATUS       = 8'h0c;
  localparam logic [7:0] IDX_OUT_CONFIG   = 8'h0d;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h21;
  localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h22;

  // ---------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------
  localparam int          CRC_RESET_BIT     = 5;
  localparam logic [7:0]  ALIAS_RESET       = 8'h00;
  localparam logic [7:0]  TARGET_RESET      = 8'h00;
  localparam logic [7:0]  OUT_CONFIG_RESET  = 8'h55;
  localparam logic [7:0]  OUT_CONFIG_WMASK  = 8'hdd;
  localparam logic [15:0] CRC_COUNT_MAX     = 16'hffff;
  // Revision code value is arbitrary.
  localparam logic [2:0]  REVISION_CODE     = 3'h5;
  localparam int          IRQ_BITS          = 4;

  // Interrupt events: far-end CRC error, self-test CRC error,
  // lock lost, link lost.
  typedef struct packed {
    logic link_lost;
    logic lock_lost;
    logic selftest_crc;
    logic far_crc;
  } ssg_irq_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] address;
    logic       read;
  } ssg_i2c_req_t;

endpackage

// ### core/ssg_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Alias in bits 7:1 selects I2C transactions for the remote target.
// - Alias of zero forwards nothing to the remote target.
// - Forwarded transaction carries stored target address instead of alias.
// - Count low byte read-only at 0x0A, reset to zero.
// - Count high byte read-only at 0x0B, sixteen bits with low byte.
// - Status bits 7:5 read a fixed revision code.
// - Status bit 4 reads back-channel receiver lock.
// - Status bit 3 reads one after self-test CRC errors.
// - Status bit 2 reads valid pixel clock detect.
// - Status bit 1 sets on far-end CRC error and stays set.
// - Far-end flag clears on link loss or CRC reset control 0x03[5].
// - Status bit 0 reads cable link detected, zero on faults.
// - Enabled, local, not remote output drives its local value bit.
// - Remote bit set: output driven from remote deserializer value.
// - Clearing remote bit stops remote control of the output.
// - Enable bit set enables pin, cleared gives high impedance.
module ssg_regs (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [9:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire ssg_pkg::ssg_i2c_req_t i2c_in,
  output ssg_pkg::ssg_i2c_req_t      remote_req,
  input  wire logic                 backchannel_crc_error,
  input  wire logic                 selftest_mode,
  input  wire logic                 rx_locked,
  input  wire logic                 pixel_clock_valid,
  input  wire logic                 link_detected,
  input  wire logic [1:0]           remote_out_value,
  output logic      [1:0]           out_pin,
  output logic      [1:0]           out_pin_oe,
  output logic                      irq
);

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  wire        access   = psel && penable;
  wire [7:0]  index    = paddr[9:2];
  wire        wr       = access && pwrite;
  wire        wr_ctl   = wr && index == ssg_pkg::IDX_CRC_CONTROL;
  wire        wr_tgt   = wr && index == ssg_pkg::IDX_TARGET_ADDR;
  wire        wr_alias = wr && index == ssg_pkg::IDX_TARGET_ALIAS;
  wire        wr_cfg   = wr && index == ssg_pkg::IDX_OUT_CONFIG;
  wire        wr_ien   = wr && index == ssg_pkg::IDX_IRQ_ENABLE;
  wire        wr_iclr  = wr && index == ssg_pkg::IDX_IRQ_CLEAR;
  wire        known    = index == ssg_pkg::IDX_CRC_CONTROL
                      || index == ssg_pkg::IDX_TARGET_ADDR
                      || index == ssg_pkg::IDX_TARGET_ALIAS
                      || index == ssg_pkg::IDX_CRC_LOW
                      || index == ssg_pkg::IDX_CRC_HIGH
                      || index == ssg_pkg::IDX_STATUS
                      || index == ssg_pkg::IDX_OUT_CONFIG
                      || index == ssg_pkg::IDX_IRQ_STATUS
                      || index == ssg_pkg::IDX_IRQ_ENABLE
                      || index == ssg_pkg::IDX_IRQ_CLEAR;

  assign pready  = 1'b1;
  assign pslverr = access && !known;

  // -----------------------------------------------------------------------
  // Stored registers
  // -----------------------------------------------------------------------
  logic [7:0]  crc_control;
  logic [7:0]  target_addr;
  logic [7:0]  target_alias;
  logic [7:0]  out_config;
  logic [15:0] crc_count;
  logic        far_crc_flag;
  logic        selftest_flag;
  logic [3:0]  irq_status;
  logic [3:0]  irq_enable;
  logic        lock_q;
  logic        link_q;

  // The reset control is a plain stored bit; the count stays held at zero
  // while software leaves it set, but a CRC error in that time still sets the flags.
  wire crc_reset = crc_control[ssg_pkg::CRC_RESET_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_control  <= 8'h00;
      target_addr  <= ssg_pkg::TARGET_RESET;
      target_alias <= ssg_pkg::ALIAS_RESET;
      out_config   <= ssg_pkg::OUT_CONFIG_RESET;
      irq_enable   <= 4'h0;
    end else begin
      if (wr_ctl)
        crc_control <= pwdata[7:0];
      if (wr_tgt)
        target_addr <= pwdata[7:0];
      if (wr_alias)
        target_alias <= pwdata[7:0];
      if (wr_cfg)
        out_config <= pwdata[7:0] & ssg_pkg::OUT_CONFIG_WMASK;
      if (wr_ien)
        irq_enable <= pwdata[3:0];
    end
  end

  // -----------------------------------------------------------------------
  // Error counting and flags
  // -----------------------------------------------------------------------
  wire count_ev  = backchannel_crc_error && !selftest_mode;
  wire far_clear = crc_reset || !link_detected;
  wire [15:0] next_crc_count =
    crc_reset ? 16'h0000 :
    (count_ev && crc_count != ssg_pkg::CRC_COUNT_MAX) ?
      16'(crc_count + 16'h0001) : crc_count;

  ssg_pkg::ssg_irq_t events;
  assign events.far_crc      = backchannel_crc_error && link_detected;
  assign events.selftest_crc = backchannel_crc_error && selftest_mode;
  assign events.lock_lost    = lock_q && !rx_locked;
  assign events.link_lost    = link_q && !link_detected;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_count     <= 16'h0000;
      far_crc_flag  <= 1'b0;
      selftest_flag <= 1'b0;
      lock_q        <= 1'b0;
      link_q        <= 1'b0;
    end else begin
      crc_count <= next_crc_count;
      if (events.far_crc)
        far_crc_flag <= 1'b1;
      else if (far_clear)
        far_crc_flag <= 1'b0;
      if (events.selftest_crc)
        selftest_flag <= 1'b1;
      else if (crc_reset)
        selftest_flag <= 1'b0;
      lock_q <= rx_locked;
      link_q <= link_detected;
    end
  end

  // -----------------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------------
  wire [3:0] ev_vec         = events;
  wire [3:0] next_irq_status =
    ev_vec | (irq_status & ~(wr_iclr ? pwdata[3:0] : 4'h0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status <= 4'h0;
    else
      irq_status <= next_irq_status;
  end

  assign irq = |(irq_status & irq_enable);

  // -----------------------------------------------------------------------
  // Status and read data
  // -----------------------------------------------------------------------
  // status layout
  wire [7:0] status = {ssg_pkg::REVISION_CODE, rx_locked, selftest_flag,
                       pixel_clock_valid, far_crc_flag, link_detected};

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (index)
      ssg_pkg::IDX_CRC_CONTROL:  rd_byte = crc_control;
      ssg_pkg::IDX_TARGET_ADDR:  rd_byte = target_addr;
      ssg_pkg::IDX_TARGET_ALIAS: rd_byte = target_alias;
      ssg_pkg::IDX_CRC_LOW:      rd_byte = crc_count[7:0];
      ssg_pkg::IDX_CRC_HIGH:     rd_byte = crc_count[15:8];
      ssg_pkg::IDX_STATUS:       rd_byte = status;
      ssg_pkg::IDX_OUT_CONFIG:   rd_byte = out_config;
      ssg_pkg::IDX_IRQ_STATUS:   rd_byte = {4'h0, irq_status};
      ssg_pkg::IDX_IRQ_ENABLE:   rd_byte = {4'h0, irq_enable};
      default:                   rd_byte = 8'h00;
    endcase
  end

  assign prdata = {24'h000000, rd_byte};

  // -----------------------------------------------------------------------
  // Remote target remap
  // -----------------------------------------------------------------------
  // alias match
  wire alias_hit = i2c_in.valid && target_alias[7:1] != 7'h00
                && i2c_in.address == target_alias[7:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      remote_req <= '0;
    else begin
      remote_req.valid   <= alias_hit;
      remote_req.address <= alias_hit ? target_addr[7:1] : 7'h00;
      remote_req.read    <= alias_hit && i2c_in.read;
    end
  end

  // -----------------------------------------------------------------------
  // Output pins
  // -----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_out
      wire en     = out_config[4*g];
      wire remote = out_config[4*g+2];
      wire local_v = out_config[4*g+3];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_pin[g]    <= 1'b0;
          out_pin_oe[g] <= 1'b0;
        end else begin
          out_pin_oe[g] <= en;
          out_pin[g]    <= remote ? remote_out_value[g] : local_v;
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // zero alias
  AST_ZERO_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
    target_alias[7:1] == 7'h00 |=> !remote_req.valid)
    else $error("Forwarded with zero alias.");
  AST_REMAP: assert property (@(posedge pclk) disable iff (!presetn)
    alias_hit |=> remote_req.valid &&
      remote_req.address == $past(target_addr[7:1]))
    else $error("Remapped address wrong.");
  AST_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
    remote_req.valid |-> $past(i2c_in.address) == $past(target_alias[7:1]))
    else $error("Forward without alias match.");
  AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    count_ev && !crc_reset && crc_count != 16'hffff
    |=> crc_count == $past(crc_count) + 16'h0001)
    else $error("Count did not step.");
  AST_SAT: assert property (@(posedge pclk) disable iff (!presetn)
    crc_count == 16'hffff && !crc_reset |=> crc_count == 16'hffff)
    else $error("Count wrapped.");
  AST_CNT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    crc_reset |=> crc_count == 16'h0000)
    else $error("Count not cleared.");
  AST_FAR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    events.far_crc |=> status[1])
    else $error("Far-end flag not set.");
  AST_FAR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    !link_detected && !events.far_crc |=> !far_crc_flag)
    else $error("Flag held after link loss.");
  AST_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    status[4] == rx_locked && status[2] == pixel_clock_valid
    && status[0] == link_detected && status[7:5] == 3'h5)
    else $error("Status bits wrong.");
  AST_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    out_config[0] && !out_config[2] |=> out_pin_oe[0]
    && out_pin[0] == $past(out_config[3]))
    else $error("Local drive wrong.");
  AST_TRI: assert property (@(posedge pclk) disable iff (!presetn)
    !out_config[4] |=> !out_pin_oe[1])
    else $error("Pin not tri-stated.");
  AST_RO: assert property (@(posedge pclk) disable iff (!presetn)
    wr && index == ssg_pkg::IDX_CRC_HIGH && !count_ev && !crc_reset
    |=> $stable(crc_count))
    else $error("Count written by bus.");
  AST_REV: assert property (@(posedge pclk) disable iff (!presetn)
    status[7:5] == ssg_pkg::REVISION_CODE)
    else $error("Revision field wrong.");

  AST_SELFTEST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    events.selftest_crc |=> status[3])
    else $error("Self-test flag not set.");

  AST_PIXEL: assert property (@(posedge pclk) disable iff (!presetn)
    status[2] == pixel_clock_valid)
    else $error("Pixel clock bit wrong.");

  AST_LINK: assert property (@(posedge pclk) disable iff (!presetn)
    status[0] == link_detected)
    else $error("Link bit wrong.");

  AST_FAR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    far_crc_flag && !far_clear |=> far_crc_flag)
    else $error("Far-end flag dropped without a clear.");

  AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    events.far_crc |=> irq_status[0])
    else $error("Interrupt status not set.");

  AST_LOW_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    index == ssg_pkg::IDX_CRC_LOW |-> rd_byte == crc_count[7:0])
    else $error("Low count byte misread.");

  AST_HIGH_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    index == ssg_pkg::IDX_CRC_HIGH |-> rd_byte == crc_count[15:8])
    else $error("High count byte misread.");

  AST_REMOTE: assert property (@(posedge pclk) disable iff (!presetn)
    out_config[2] |=> out_pin[0] == $past(remote_out_value[0]))
    else $error("Remote drive wrong.");

  AST_LOCAL1: assert property (@(posedge pclk) disable iff (!presetn)
    !out_config[6] |=> out_pin[1] == $past(out_config[7]))
    else $error("Remote still drives the pin.");

  AST_EN0: assert property (@(posedge pclk) disable iff (!presetn)
    out_config[0] |=> out_pin_oe[0])
    else $error("Pin not enabled.");

  // A self-test error also lands in the far-end flag while the link is up;
  // only the running count keeps self-test errors out.
  COV_SELFTEST: cover property (@(posedge pclk) events.selftest_crc);
  COV_FWD: cover property (@(posedge pclk) remote_req.valid);
  COV_SAT: cover property (@(posedge pclk) crc_count == 16'hffff);
  COV_IRQ: cover property (@(posedge pclk) irq);
  COV_REM: cover property (@(posedge pclk) out_config[2] && out_pin_oe[0]);

endmodule // ssg_regs

// ### dv/ssg_remote_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Remote deserializer stand-in
// ---------------------------------------------------------------------
// Counts forwarded requests so that a late or doubled request shows up.
module ssg_remote_model (
  input  wire ssg_pkg::ssg_i2c_req_t remote_req,
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  output logic [1:0]                 remote_out_value,
  output logic                       backchannel_crc_error
);
  logic [6:0] last_addr;
  int         req_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr <= 7'h00;
      req_count <= 0;
    end else if (remote_req.valid) begin
      last_addr <= remote_req.address;
      req_count <= req_count + 1;
    end
  end

  task automatic set_out(input logic [1:0] v);
    @(posedge pclk);
    remote_out_value <= v;
  endtask

  // One error is a single-cycle pulse, with a gap before the next one.
  task automatic send_errors(input int n);
    repeat (n) begin
      @(posedge pclk);
      backchannel_crc_error <= 1'b1;
      @(posedge pclk);
      backchannel_crc_error <= 1'b0;
    end
  endtask

  initial begin
    remote_out_value      = 2'h0;
    backchannel_crc_error = 1'b0;
  end
endmodule // ssg_remote_model

// ### dv/testbench.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Register bank bench
// ---------------------------------------------------------------------
module testbench;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [9:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  last_err;
  ssg_pkg::ssg_i2c_req_t i2c_in;
  ssg_pkg::ssg_i2c_req_t remote_req;
  logic                  crc_err;
  logic                  selftest_mode;
  logic                  rx_locked;
  logic                  pixel_clock_valid;
  logic                  link_detected;
  logic [1:0]            remote_out_value;
  logic [1:0]            out_pin;
  logic [1:0]            out_pin_oe;
  logic                  irq;
  int                    fail_count;
  int                    check_count;

  ssg_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i2c_in(i2c_in),
    .remote_req(remote_req), .backchannel_crc_error(crc_err),
    .selftest_mode(selftest_mode), .rx_locked(rx_locked),
    .pixel_clock_valid(pixel_clock_valid),
    .link_detected(link_detected), .remote_out_value(remote_out_value),
    .out_pin(out_pin), .out_pin_oe(out_pin_oe), .irq(irq)
  );

  ssg_remote_model model (
    .remote_req(remote_req), .pclk(pclk), .presetn(presetn),
    .remote_out_value(remote_out_value), .backchannel_crc_error(crc_err)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Starts one edge late so a release and a new setup never collide.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, idx, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'b0, idx, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask

  task automatic send_i2c(input logic [6:0] a);
    @(posedge pclk);
    i2c_in <= {1'b1, a, 1'b1};
    @(posedge pclk);
    i2c_in <= '0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h0; pwdata = 32'h0; i2c_in = '0; selftest_mode = 1'b0;
    rx_locked = 1'b0; pixel_clock_valid = 1'b0; link_detected = 1'b0;
    fail_count = 0; check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ssg_pkg::IDX_TARGET_ALIAS, 8'h00);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h00);
    rd(ssg_pkg::IDX_CRC_HIGH, 8'h00);
    rd(ssg_pkg::IDX_STATUS, 8'ha0);
    rd(ssg_pkg::IDX_OUT_CONFIG, 8'h55);
    chk(out_pin_oe, 2'b11);
    rd(8'h10, 8'h00);
    chk(last_err, 1'b1);
    wr(ssg_pkg::IDX_TARGET_ADDR, 8'h84);
    send_i2c(7'h00);
    chk(model.req_count, 0);
    wr(ssg_pkg::IDX_TARGET_ALIAS, 8'h60);
    send_i2c(7'h31);
    send_i2c(7'h30);
    chk(model.req_count, 1);
    chk(model.last_addr, 7'h42);
    rx_locked <= 1'b1;
    pixel_clock_valid <= 1'b1;
    link_detected <= 1'b1;
    rd(ssg_pkg::IDX_STATUS, 8'hb5);
    model.send_errors(3);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h03);
    rd(ssg_pkg::IDX_CRC_HIGH, 8'h00);
    wr(ssg_pkg::IDX_CRC_LOW, 8'hff);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h03);
    rd(ssg_pkg::IDX_STATUS, 8'hb7);
    wr(ssg_pkg::IDX_CRC_CONTROL, 8'h20);
    wr(ssg_pkg::IDX_CRC_CONTROL, 8'h00);
    rd(ssg_pkg::IDX_CRC_LOW, 8'h00);
    rd(ssg_pkg::IDX_STATUS, 8'hb5);
    model.send_errors(1);
    link_detected <= 1'b0;
    rd(ssg_pkg::IDX_STATUS, 8'hb4);
    link_detected <= 1'b1;
    rd(ssg_pkg::IDX_STATUS, 8'hb5);
    selftest_mode <= 1'b1;
    model.send_errors(2);
    selftest_mode <= 1'b0;
    rd(ssg_pkg::IDX_STATUS, 8'hbf);
    wr(ssg_pkg::IDX_IRQ_CLEAR, 8'h0f);
    wr(ssg_pkg::IDX_IRQ_ENABLE, 8'h01);
    chk(irq, 1'b0);
    model.send_errors(1);
    rd(ssg_pkg::IDX_IRQ_STATUS, 8'h01);
    chk(irq, 1'b1);
    wr(ssg_pkg::IDX_IRQ_ENABLE, 8'h00);
    @(negedge pclk);
    chk(irq, 1'b0);
    wr(ssg_pkg::IDX_IRQ_ENABLE, 8'h01);
    wr(ssg_pkg::IDX_IRQ_CLEAR, 8'h01);
    rd(ssg_pkg::IDX_IRQ_STATUS, 8'h00);
    chk(irq, 1'b0);
    model.set_out(2'b10);
    repeat (3) @(posedge pclk);
    chk(out_pin, 2'b10);
    wr(ssg_pkg::IDX_OUT_CONFIG, 8'h91);
    model.set_out(2'b01);
    repeat (3) @(posedge pclk);
    chk(out_pin, 2'b10);
    rd(ssg_pkg::IDX_OUT_CONFIG, 8'h91);
    wr(ssg_pkg::IDX_OUT_CONFIG, 8'h99);
    repeat (3) @(posedge pclk);
    chk(out_pin, 2'b11);
    wr(ssg_pkg::IDX_OUT_CONFIG, 8'h22);
    repeat (3) @(posedge pclk);
    chk(out_pin_oe, 2'b00);
    rd(ssg_pkg::IDX_OUT_CONFIG, 8'h00);
    rx_locked <= 1'b0;
    pixel_clock_valid <= 1'b0;
    rd(ssg_pkg::IDX_STATUS, 8'hab);
    rd(ssg_pkg::IDX_IRQ_STATUS, 8'h04);
    tally_and_finish();
  end
endmodule // testbench
